// *** core/alcu_core.sv ***
// accumulator logic and compare unit with its register port
// assumes the sequencer and data memory run on the same clock and keep requests until ready
//
// How it works
// - formatted and: accumulator and trimmed discrete run
// - wide or formatted result zero sets zero flag
// - wide or formatted result negative sets negative flag
// - negative means accumulator bit 31 is one
// - word or: low accumulator or memory word
// - wide or: accumulator or 32-bit constant
// - formatted or: accumulator or trimmed run
// - word xor: low accumulator xor memory word
// - wide xor: accumulator xor 32-bit constant
// - formatted xor: accumulator xor trimmed run
// - every logic result replaces the accumulator
// - word or/xor update only the zero flag
// - compare low accumulator with memory word, flag outcome
// - compare leaves exactly one of less, equal, greater
//
// Design decisions made here: the strobed register port and the placing of the registers.
module alcu_core (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  // operation request from the sequencer
  input wire logic OP_VALID_IN,
  input wire logic [3:0] OP_CODE_IN,
  input wire logic [15:0] MEM_WORD_IN,
  input wire logic [31:0] WIDE_CONST_IN,
  input wire logic [31:0] RUN_BITS_IN,
  input wire logic [5:0] RUN_COUNT_IN,
  // operation answer to the sequencer
  output logic OP_READY_OUT,
  output logic OP_DONE_OUT,
  output logic [31:0] ACC_OUT,
  // status flags
  output logic ZERO_FLAG_OUT,
  output logic NEGATIVE_FLAG_OUT,
  output logic LESS_FLAG_OUT,
  output logic EQUAL_FLAG_OUT,
  output logic GREATER_FLAG_OUT,
  // register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  // interrupt
  output logic IRQ_OUT
);

  // sequencer state
  alcu_pkg::alcu_state_t state;
  // latched operation and operands
  alcu_pkg::alcu_op_t op;
  logic [15:0] word;
  logic [31:0] wide;
  logic [31:0] run_bits;
  logic [5:0] run_count;
  // accumulator and flags
  logic [31:0] acc;
  logic zero_flag;
  logic negative_flag;
  logic less_flag;
  logic equal_flag;
  logic greater_flag;
  // software registers
  logic ctrl_en;
  logic [3:0] status;
  logic [3:0] mask;
  // incoming opcode in enum form
  alcu_pkg::alcu_op_t op_in;
  // request accepted this cycle
  logic take;
  // refusal reasons for a request seen this cycle
  logic refuse_off;
  logic refuse_badop;
  logic refuse_badcnt;
  // trimmed run
  logic [31:0] run_masked;
  // result candidate and flag candidates
  logic [31:0] next_acc;
  logic writes_acc;
  logic upd_zero32;
  logic upd_zero16;
  logic upd_cmp;
  logic cand_zero32;
  logic cand_zero16;
  logic cand_neg;
  logic cand_less;
  logic cand_equal;
  logic cand_greater;
  // status events and next status
  logic [3:0] status_set;
  logic [3:0] next_status;
  // register strobes
  logic wr_ctrl;
  logic wr_mask;
  logic wr_acc;
  logic rd_status;

  // run trimming to its bit count
  alcu_run_mask u_run_mask (
    .run_bits_in(run_bits),
    .run_count_in(run_count),
    .run_masked_out(run_masked)
  );

  // flag candidates for the result being formed
  alcu_flag_eval u_flag_eval (
    .result_in(next_acc),
    .acc_low_in(acc[15:0]),
    .word_in(word),
    .zero32_out(cand_zero32),
    .zero16_out(cand_zero16),
    .negative_out(cand_neg),
    .less_out(cand_less),
    .equal_out(cand_equal),
    .greater_out(cand_greater)
  );

  // opcode decode and request screening
  always_comb begin
    op_in = alcu_pkg::alcu_op_t'(OP_CODE_IN);
    refuse_off = 1'b0;
    refuse_badop = 1'b0;
    refuse_badcnt = 1'b0;
    take = 1'b0;
    if (OP_VALID_IN && (state == alcu_pkg::ALCU_ST_IDLE)) begin
      // unit switched off by software
      if (!ctrl_en) begin
        refuse_off = 1'b1;
      // unknown opcode
      end else if ((OP_CODE_IN == 4'h0) || (OP_CODE_IN > 4'h8)) begin
        refuse_badop = 1'b1;
      // run length outside one to thirty-two
      end else if (alcu_pkg::is_run_op(op_in) && !alcu_pkg::run_count_ok(RUN_COUNT_IN)) begin
        refuse_badcnt = 1'b1;
      end else begin
        take = 1'b1;
      end
    end
  end

  // result and flag selection per operation
  always_comb begin
    next_acc = acc;
    writes_acc = 1'b0;
    upd_zero32 = 1'b0;
    upd_zero16 = 1'b0;
    upd_cmp = 1'b0;
    case (op)
      // word or keeps the upper half
      alcu_pkg::ALCU_OP_OR_WORD: begin
        next_acc = {acc[31:16], acc[15:0] | word};
        writes_acc = 1'b1;
        upd_zero16 = 1'b1;
      end
      // wide or with the constant
      alcu_pkg::ALCU_OP_OR_WIDE: begin
        next_acc = acc | wide;
        writes_acc = 1'b1;
        upd_zero32 = 1'b1;
      end
      // formatted or
      alcu_pkg::ALCU_OP_OR_RUN: begin
        next_acc = acc | run_masked;
        writes_acc = 1'b1;
        upd_zero32 = 1'b1;
      end
      // word xor keeps the upper half
      alcu_pkg::ALCU_OP_XOR_WORD: begin
        next_acc = {acc[31:16], acc[15:0] ^ word};
        writes_acc = 1'b1;
        upd_zero16 = 1'b1;
      end
      // wide xor with the constant
      alcu_pkg::ALCU_OP_XOR_WIDE: begin
        next_acc = acc ^ wide;
        writes_acc = 1'b1;
        upd_zero32 = 1'b1;
      end
      // formatted xor
      alcu_pkg::ALCU_OP_XOR_RUN: begin
        next_acc = acc ^ run_masked;
        writes_acc = 1'b1;
        upd_zero32 = 1'b1;
      end
      // formatted and
      alcu_pkg::ALCU_OP_AND_RUN: begin
        next_acc = acc & run_masked;
        writes_acc = 1'b1;
        upd_zero32 = 1'b1;
      end
      // compare leaves the accumulator alone
      alcu_pkg::ALCU_OP_CMP_WORD: begin
        upd_cmp = 1'b1;
      end
      // nothing latched
      default: begin
        next_acc = acc;
      end
    endcase
  end

  // sequencer: one cycle to latch, one cycle to execute
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      state <= alcu_pkg::ALCU_ST_IDLE;
    end else begin
      case (state)
        // wait for an accepted request
        alcu_pkg::ALCU_ST_IDLE: begin
          if (take) begin
            state <= alcu_pkg::ALCU_ST_EXEC;
          end
        end
        // result written at the end of this cycle
        alcu_pkg::ALCU_ST_EXEC: begin
          state <= alcu_pkg::ALCU_ST_IDLE;
        end
        // recover to idle
        default: begin
          state <= alcu_pkg::ALCU_ST_IDLE;
        end
      endcase
    end
  end

  // operand latch on acceptance
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      op <= alcu_pkg::ALCU_OP_NONE;
      word <= 16'h0000;
      wide <= 32'h0000_0000;
      run_bits <= 32'h0000_0000;
      run_count <= 6'h00;
    end else if (take) begin
      op <= op_in;
      word <= MEM_WORD_IN;
      wide <= WIDE_CONST_IN;
      run_bits <= RUN_BITS_IN;
      run_count <= RUN_COUNT_IN;
    end
  end

  // handshake outputs
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      OP_READY_OUT <= 1'b1;
      OP_DONE_OUT <= 1'b0;
    end else begin
      OP_READY_OUT <= !take;
      OP_DONE_OUT <= (state == alcu_pkg::ALCU_ST_EXEC);
    end
  end

  // accumulator: result write-back wins over a software write
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      acc <= alcu_pkg::ALCU_ACC_RST;
    end else if ((state == alcu_pkg::ALCU_ST_EXEC) && writes_acc) begin
      acc <= next_acc;
    end else if (wr_acc && (state == alcu_pkg::ALCU_ST_IDLE) && !take) begin
      acc <= REG_WDATA_IN;
    end
  end

  // zero and negative flags hold until an operation writes them
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      zero_flag <= 1'b0;
      negative_flag <= 1'b0;
    end else if (state == alcu_pkg::ALCU_ST_EXEC) begin
      if (upd_zero32) begin
        zero_flag <= cand_zero32;
        negative_flag <= cand_neg;
      end else if (upd_zero16) begin
        zero_flag <= cand_zero16;
      end
    end
  end

  // compare flags, exactly one set per compare
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      less_flag <= 1'b0;
      equal_flag <= 1'b0;
      greater_flag <= 1'b0;
    end else if ((state == alcu_pkg::ALCU_ST_EXEC) && upd_cmp) begin
      less_flag <= cand_less;
      equal_flag <= cand_equal;
      greater_flag <= cand_greater;
    end
  end

  // accumulator and flags to the sequencer
  assign ACC_OUT = acc;
  assign ZERO_FLAG_OUT = zero_flag;
  assign NEGATIVE_FLAG_OUT = negative_flag;
  assign LESS_FLAG_OUT = less_flag;
  assign EQUAL_FLAG_OUT = equal_flag;
  assign GREATER_FLAG_OUT = greater_flag;

  // register strobes
  assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == alcu_pkg::ALCU_REG_CTRL);
  assign wr_mask = REG_WR_IN && (REG_ADDR_IN == alcu_pkg::ALCU_REG_MASK);
  assign wr_acc = REG_WR_IN && (REG_ADDR_IN == alcu_pkg::ALCU_REG_ACC);
  assign rd_status = REG_RD_IN && (REG_ADDR_IN == alcu_pkg::ALCU_REG_STATUS);

  // sticky events; a new event beats the clear of a status read
  always_comb begin
    status_set = 4'h0;
    status_set[alcu_pkg::ALCU_ST_DONE_BIT] = (state == alcu_pkg::ALCU_ST_EXEC);
    status_set[alcu_pkg::ALCU_ST_BADCNT_BIT] = refuse_badcnt;
    status_set[alcu_pkg::ALCU_ST_BADOP_BIT] = refuse_badop;
    status_set[alcu_pkg::ALCU_ST_OFF_BIT] = refuse_off;
    next_status = (rd_status ? 4'h0 : status) | status_set;
  end

  // control and mask registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      ctrl_en <= alcu_pkg::ALCU_CTRL_RST;
      mask <= alcu_pkg::ALCU_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_en <= REG_WDATA_IN[alcu_pkg::ALCU_CTRL_EN_BIT];
      end
      if (wr_mask) begin
        mask <= REG_WDATA_IN[3:0];
      end
    end
  end

  // status register and interrupt line
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      status <= alcu_pkg::ALCU_STATUS_RST;
      IRQ_OUT <= 1'b0;
    end else begin
      status <= next_status;
      IRQ_OUT <= |(next_status & mask);
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      REG_RDATA_OUT <= 32'h0000_0000;
    end else if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        alcu_pkg::ALCU_REG_CTRL: REG_RDATA_OUT <= {31'h0, ctrl_en}; // enable bit
        alcu_pkg::ALCU_REG_STATUS: REG_RDATA_OUT <= {28'h0, status}; // sticky events before this read clears them
        alcu_pkg::ALCU_REG_MASK: REG_RDATA_OUT <= {28'h0, mask}; // interrupt mask
        alcu_pkg::ALCU_REG_ACC: REG_RDATA_OUT <= acc; // accumulator
        alcu_pkg::ALCU_REG_FLAGS: REG_RDATA_OUT <= {27'h0, greater_flag, equal_flag, // current flags
          less_flag, negative_flag, zero_flag};
        default: REG_RDATA_OUT <= 32'h0000_0000; // unmapped reads as zero
      endcase
    end else begin
      REG_RDATA_OUT <= 32'h0000_0000;
    end
  end

endmodule

// *** core/alcu_flag_eval.sv ***
// evaluates status flags for a candidate result and a compare
// assumes unsigned compare of the low accumulator word against the memory word
module alcu_flag_eval (
  // candidate accumulator result
  input wire logic [31:0] result_in,
  // compare operands
  input wire logic [15:0] acc_low_in,
  input wire logic [15:0] word_in,
  // flag candidates
  output logic zero32_out,
  output logic zero16_out,
  output logic negative_out,
  output logic less_out,
  output logic equal_out,
  output logic greater_out
);

  // zero on the whole accumulator
  assign zero32_out = (result_in == 32'h0000_0000);
  // zero on the word result of a word operation
  assign zero16_out = (result_in[15:0] == 16'h0000);
  // negative when the top accumulator bit is one
  assign negative_out = result_in[31];
  // exactly one compare outcome is ever high
  assign less_out = (acc_low_in < word_in);
  assign equal_out = (acc_low_in == word_in);
  assign greater_out = (acc_low_in > word_in);

endmodule

// *** core/alcu_pkg.sv ***
// constants, opcodes, states and register map of the accumulator logic unit
// assumes one 50 MHz clock and a synchronous active-low reset in every user
package alcu_pkg;

  // operation codes offered by the instruction sequencer
  typedef enum logic [3:0] {
    ALCU_OP_NONE       = 4'h0,
    ALCU_OP_OR_WORD    = 4'h1,
    ALCU_OP_OR_WIDE    = 4'h2,
    ALCU_OP_OR_RUN     = 4'h3,
    ALCU_OP_XOR_WORD   = 4'h4,
    ALCU_OP_XOR_WIDE   = 4'h5,
    ALCU_OP_XOR_RUN    = 4'h6,
    ALCU_OP_AND_RUN    = 4'h7,
    ALCU_OP_CMP_WORD   = 4'h8
  } alcu_op_t;

  // execution sequencer states
  typedef enum logic [0:0] {
    ALCU_ST_IDLE = 1'b0,
    ALCU_ST_EXEC = 1'b1
  } alcu_state_t;

  // widths
  localparam int unsigned ALCU_ACC_W = 32;
  localparam int unsigned ALCU_WORD_W = 16;
  localparam int unsigned ALCU_CNT_W = 6;
  localparam int unsigned ALCU_ADDR_W = 8;

  // discrete run length limits
  localparam logic [5:0] ALCU_RUN_MIN = 6'h01;
  localparam logic [5:0] ALCU_RUN_MAX = 6'h20;

  // register byte offsets
  localparam logic [7:0] ALCU_REG_CTRL = 8'h00;
  localparam logic [7:0] ALCU_REG_STATUS = 8'h04;
  localparam logic [7:0] ALCU_REG_MASK = 8'h08;
  localparam logic [7:0] ALCU_REG_ACC = 8'h0C;
  localparam logic [7:0] ALCU_REG_FLAGS = 8'h10;

  // control, status and flag field positions
  localparam int unsigned ALCU_CTRL_EN_BIT = 0;
  localparam int unsigned ALCU_ST_DONE_BIT = 0;
  localparam int unsigned ALCU_ST_BADCNT_BIT = 1;
  localparam int unsigned ALCU_ST_BADOP_BIT = 2;
  localparam int unsigned ALCU_ST_OFF_BIT = 3;
  localparam int unsigned ALCU_FL_ZERO_BIT = 0;
  localparam int unsigned ALCU_FL_NEG_BIT = 1;
  localparam int unsigned ALCU_FL_LESS_BIT = 2;
  localparam int unsigned ALCU_FL_EQUAL_BIT = 3;
  localparam int unsigned ALCU_FL_GREATER_BIT = 4;

  // values after reset
  localparam logic ALCU_CTRL_RST = 1'b1;
  localparam logic [3:0] ALCU_STATUS_RST = 4'h0;
  localparam logic [3:0] ALCU_MASK_RST = 4'h0;
  localparam logic [31:0] ALCU_ACC_RST = 32'h0000_0000;

  // a run length is legal from one to thirty-two bits
  function automatic logic run_count_ok(input logic [5:0] cnt);
    run_count_ok = (cnt >= ALCU_RUN_MIN) && (cnt <= ALCU_RUN_MAX);
  endfunction

  // operations that take a discrete run operand
  function automatic logic is_run_op(input alcu_op_t op);
    is_run_op = (op == ALCU_OP_OR_RUN) || (op == ALCU_OP_XOR_RUN) || (op == ALCU_OP_AND_RUN);
  endfunction

endpackage

// *** core/alcu_run_mask.sv ***
// trims a fetched run of discrete bits to its bit count
// assumes bit 0 of the run is the bit at the start location
module alcu_run_mask (
  // run as fetched from discrete memory
  input wire logic [31:0] run_bits_in,
  input wire logic [5:0] run_count_in,
  // run with bits at or above the count forced low
  output logic [31:0] run_masked_out
);

  // one mask bit per position, high below the count
  logic [31:0] keep;

  // bits at or above the count read as zero
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_keep
      assign keep[gi] = (run_count_in > 6'(gi));
    end
  endgenerate

  // apply the mask
  assign run_masked_out = run_bits_in & keep;

endmodule

// *** dv/alcu_core_monitor.sv ***
// concurrent checks on the ports of the logic and compare unit
// assumes one clock; operands are sampled at the taking edge
module alcu_core_monitor (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  // request
  input wire logic OP_VALID_IN,
  input wire logic [3:0] OP_CODE_IN,
  input wire logic [15:0] MEM_WORD_IN,
  input wire logic [31:0] WIDE_CONST_IN,
  input wire logic [31:0] RUN_BITS_IN,
  input wire logic [5:0] RUN_COUNT_IN,
  // answer and flags
  input wire logic OP_READY_OUT,
  input wire logic OP_DONE_OUT,
  input wire logic [31:0] ACC_OUT,
  input wire logic ZERO_FLAG_OUT,
  input wire logic NEGATIVE_FLAG_OUT,
  input wire logic LESS_FLAG_OUT,
  input wire logic EQUAL_FLAG_OUT,
  input wire logic GREATER_FLAG_OUT,
  // register port
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [31:0] REG_RDATA_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  // a take drops ready for one cycle, then done comes
  a_take_to_done: assert property ((OP_VALID_IN && OP_READY_OUT) ##1 !OP_READY_OUT |-> ##1 (OP_DONE_OUT && OP_READY_OUT))
    else $error("done missing two cycles after a take");
  a_done_single: assert property (OP_DONE_OUT |=> !OP_DONE_OUT)
    else $error("done longer than one cycle");
  a_done_cause: assert property (OP_DONE_OUT |-> $past(OP_VALID_IN, 2) && !$past(OP_READY_OUT))
    else $error("done without a taken request");
  a_wide_or_result: assert property (OP_DONE_OUT && $past(OP_CODE_IN, 2) == 4'h2 |->
    ACC_OUT == ($past(ACC_OUT, 2) | $past(WIDE_CONST_IN, 2))) else $error("wide or result wrong");
  a_word_xor_result: assert property (OP_DONE_OUT && $past(OP_CODE_IN, 2) == 4'h4 |->
    ACC_OUT == {$past(ACC_OUT[31:16], 2), $past(ACC_OUT[15:0], 2) ^ $past(MEM_WORD_IN, 2)} &&
    ZERO_FLAG_OUT == (ACC_OUT[15:0] == 16'h0000) && NEGATIVE_FLAG_OUT == $past(NEGATIVE_FLAG_OUT))
    else $error("word xor result or flags wrong");
  a_run_and_result: assert property (OP_DONE_OUT && $past(OP_CODE_IN, 2) == 4'h7 |->
    ACC_OUT == ($past(ACC_OUT, 2) & $past(RUN_BITS_IN, 2) & (32'hFFFF_FFFF >> (6'h20 - $past(RUN_COUNT_IN, 2)))))
    else $error("run and result wrong");
  a_wide_run_flags: assert property (OP_DONE_OUT && $past(OP_CODE_IN, 2) inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7} |->
    ZERO_FLAG_OUT == (ACC_OUT == 32'h0) && NEGATIVE_FLAG_OUT == ACC_OUT[31])
    else $error("zero or negative flag wrong");
  a_cmp_outcome: assert property (OP_DONE_OUT && $past(OP_CODE_IN, 2) == 4'h8 |->
    {GREATER_FLAG_OUT, EQUAL_FLAG_OUT, LESS_FLAG_OUT} == {$past(ACC_OUT[15:0], 2) > $past(MEM_WORD_IN, 2),
    $past(ACC_OUT[15:0], 2) == $past(MEM_WORD_IN, 2), $past(ACC_OUT[15:0], 2) < $past(MEM_WORD_IN, 2)} &&
    ACC_OUT == $past(ACC_OUT, 2)) else $error("compare flags wrong");
  a_acc_steady: assert property (!OP_DONE_OUT && !$past(REG_WR_IN) |-> $stable(ACC_OUT))
    else $error("accumulator changed without cause");
  a_rdata_idle: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0)
    else $error("read data outside read cycle");
endmodule
bind alcu_core alcu_core_monitor mon_u (.CLK_SYS_IN(CLK_SYS_IN), .RST_B_IN(RST_B_IN), .OP_VALID_IN(OP_VALID_IN),
  .OP_CODE_IN(OP_CODE_IN), .MEM_WORD_IN(MEM_WORD_IN), .WIDE_CONST_IN(WIDE_CONST_IN), .RUN_BITS_IN(RUN_BITS_IN),
  .RUN_COUNT_IN(RUN_COUNT_IN), .OP_READY_OUT(OP_READY_OUT), .OP_DONE_OUT(OP_DONE_OUT), .ACC_OUT(ACC_OUT),
  .ZERO_FLAG_OUT(ZERO_FLAG_OUT), .NEGATIVE_FLAG_OUT(NEGATIVE_FLAG_OUT), .LESS_FLAG_OUT(LESS_FLAG_OUT),
  .EQUAL_FLAG_OUT(EQUAL_FLAG_OUT), .GREATER_FLAG_OUT(GREATER_FLAG_OUT), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT));

// *** dv/alcu_core_tb.sv ***
// self-checking bench of the logic and compare unit
// assumes a 50 MHz clock; the bench plays the instruction sequencer
module alcu_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0; // active low reset
  logic op_valid = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [31:0] wide_const = 32'h0, run_bits = 32'h0, reg_wdata = 32'h0;
  logic [5:0] run_count = 6'h01;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, mem_wr = 1'b0, rd_pend = 1'b0;
  logic [3:0] mem_addr = 4'h0;
  logic [15:0] mem_wdata = 16'h0000, mem_word;
  logic ready, done, irq;
  logic [31:0] acc, reg_rdata;
  wire [4:0] flags; // zero, negative, less, equal, greater from bit 0
  logic [31:0] acc_m = 32'h0; // expected accumulator
  logic [4:0] flag_m = 5'h00; // expected flags
  logic [15:0] mirror [16]; // bench copy of data memory
  logic [36:0] op_q [$]; // expected results in order
  logic [31:0] rd_q [$]; // expected read data
  int fail_count = 0;
  int num_checks = 0;
  always #10 clk = ~clk;
  alcu_mem_model dm_u (.clk_in(clk), .wr_in(mem_wr), .addr_in(mem_addr), .wdata_in(mem_wdata), .word_out(mem_word));
  alcu_core dut_u (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .OP_VALID_IN(op_valid), .OP_CODE_IN(op_code),
    .MEM_WORD_IN(mem_word), .WIDE_CONST_IN(wide_const), .RUN_BITS_IN(run_bits), .RUN_COUNT_IN(run_count),
    .OP_READY_OUT(ready), .OP_DONE_OUT(done), .ACC_OUT(acc), .ZERO_FLAG_OUT(flags[0]),
    .NEGATIVE_FLAG_OUT(flags[1]), .LESS_FLAG_OUT(flags[2]), .EQUAL_FLAG_OUT(flags[3]),
    .GREATER_FLAG_OUT(flags[4]), .REG_ADDR_IN(reg_addr), .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr),
    .REG_RD_IN(reg_rd), .REG_RDATA_OUT(reg_rdata), .IRQ_OUT(irq));
  // compare and count
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // drop the request and register strobes and let cycles pass
  task automatic idle(input int n);
    op_valid <= 1'b0;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  // one register write cycle; strobe held for a following write
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
  endtask
  // one register read cycle; data expected in the next cycle
  task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    reg_wr <= 1'b0;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
  endtask
  // present a request, note its result, hold until taken
  task automatic do_op(input logic [3:0] c, input logic [3:0] ma, input logic [31:0] w, input logic [31:0] rb,
    input logic [5:0] n);
    logic [15:0] mw;
    logic [31:0] run;
    int k;
    mw = mirror[ma];
    run = rb & (32'hFFFF_FFFF >> (6'h20 - n));
    case (c)
      4'h1: acc_m[15:0] = acc_m[15:0] | mw;
      4'h2: acc_m = acc_m | w;
      4'h3: acc_m = acc_m | run;
      4'h4: acc_m[15:0] = acc_m[15:0] ^ mw;
      4'h5: acc_m = acc_m ^ w;
      4'h6: acc_m = acc_m ^ run;
      4'h7: acc_m = acc_m & run;
      default: flag_m[4:2] = {acc_m[15:0] > mw, acc_m[15:0] == mw, acc_m[15:0] < mw};
    endcase
    if (c == 4'h1 || c == 4'h4) flag_m[0] = (acc_m[15:0] == 16'h0000);
    else if (c != 4'h8) flag_m[1:0] = {acc_m[31], acc_m == 32'h0};
    op_q.push_back({acc_m, flag_m});
    op_code <= c;
    mem_addr <= ma;
    wide_const <= w;
    run_bits <= rb;
    run_count <= n;
    op_valid <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ready !== 1'b1 && k < 8);
    if (k >= 8) begin
      fail_count++;
      conclude();
    end
  endtask
  // a request that must be refused, then its status bit read back
  task automatic bad_req(input logic [3:0] c, input logic [5:0] n, input logic [31:0] e);
    op_code <= c;
    run_count <= n;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    @(posedge clk);
    check(ready, 1'b1);
    check(irq, 1'b1);
    reg_read(8'h04, e);
    idle(1);
    check(irq, 1'b0);
  endtask
  // result watcher: each done takes the oldest note; flags are consumed here before the next op
  always @(posedge clk) begin
    rd_pend <= reg_rd;
    if (rd_pend) check({5'h00, reg_rdata}, {5'h00, rd_q.pop_front()});
    if (done === 1'b1 && op_q.size() > 0) check({acc, flags}, op_q.pop_front());
    else if (done === 1'b1) check(37'h0, 37'h1);
  end
  // main sequence
  initial begin
    void'($urandom(32'h5346));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      mirror[i] = (i == 0) ? 16'h0000 : 16'($urandom);
      mem_addr <= 4'(i);
      mem_wdata <= mirror[i];
      mem_wr <= 1'b1;
      @(posedge clk);
    end
    mem_wr <= 1'b0;
    for (int i = 0; i < 6; i++) reg_read(8'(4 * i), (i == 0) ? 32'h1 : 32'h0);
    idle(2);
    $display("test reset values done");
    for (int r = 0; r < 64; r++)
      do_op(4'(1 + r % 8), 4'($urandom), $urandom, $urandom, (r % 3 == 0) ? 6'h20 : (r % 3 == 1) ? 6'h01 :
        6'(1 + $urandom % 32));
    idle(3);
    reg_read(8'h04, 32'h1);
    reg_read(8'h10, {27'h0, flag_m});
    reg_read(8'h0C, acc_m);
    idle(1);
    $display("test back-to-back operations done");
    reg_write(8'h0C, 32'h8000_0001);
    idle(1);
    acc_m = 32'h8000_0001;
    do_op(4'h5, 4'h0, 32'h8000_0001, 32'h0, 6'h01);
    do_op(4'h2, 4'h0, 32'h8000_0000, 32'h0, 6'h01);
    do_op(4'h1, 4'h0, 32'h0, 32'h0, 6'h01);
    do_op(4'h7, 4'h0, 32'h0, 32'hFFFF_FFFF, 6'h20);
    do_op(4'h6, 4'h0, 32'h0, 32'hFFFF_FFFF, 6'h01);
    do_op(4'h8, 4'h0, 32'h0, 32'h0, 6'h01);
    idle(3);
    reg_write(8'h0C, {16'h0000, mirror[5]});
    idle(1);
    acc_m = {16'h0000, mirror[5]};
    do_op(4'h8, 4'h5, 32'h0, 32'h0, 6'h01);
    do_op(4'h4, 4'h5, 32'h0, 32'h0, 6'h01);
    do_op(4'h8, 4'h5, 32'h0, 32'h0, 6'h01);
    idle(3);
    $display("test flag corners done");
    check(irq, 1'b0);
    reg_write(8'h08, 32'hF);
    idle(2);
    check(irq, 1'b1);
    reg_read(8'h04, 32'h1);
    idle(2);
    check(irq, 1'b0);
    $display("test interrupt done");
    bad_req(4'h0, 6'h01, 32'h4);
    bad_req(4'h9, 6'h01, 32'h4);
    bad_req(4'h3, 6'h00, 32'h2);
    bad_req(4'h7, 6'h21, 32'h2);
    reg_write(8'h00, 32'h0);
    idle(1);
    bad_req(4'h2, 6'h01, 32'h8);
    reg_write(8'h00, 32'h1);
    reg_read(8'h0C, acc_m);
    idle(2);
    $display("test refusals done");
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    reg_read(8'h0C, 32'h0);
    reg_read(8'h08, 32'h0);
    idle(2);
    check(37'(op_q.size()), 37'h0);
    $display("test second reset done");
    conclude();
  end
endmodule

// *** dv/alcu_mem_model.sv ***
// data memory model that feeds word operands to the logic unit
// assumes the bench loads every location before it is read
module alcu_mem_model (
  // clock
  input wire logic clk_in,
  // load port
  input wire logic wr_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  // word at the addressed location
  output logic [15:0] word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16]; // sixteen word locations
  // load a word on a strobe
  always_ff @(posedge clk_in) begin
    if (wr_in) mem[addr_in] <= wdata_in;
  end
  // the addressed word is presented at once
  assign word_out = mem[addr_in];
endmodule
